// *** include/dtc_defs.vh ***
/*
 constants for the disk transfer command control block.
 assumes an apb slave with an 8-bit byte address and 32-bit data.
*/
//
// Overview of operation
// - modifier bit 0 set: no completion interrupt for that command
// - bits 7 and 6 on fixed-disk read/write data: direct, bus locked
// - direct mode: one memory access per byte or word moved
// - overrun or late in direct: rewind pointers, rebuffer that sector
// - floppy direct or buffered choice comes from the two floppy straps
// - floppy direct transfers never lock the system bus
// - bits 5 and 7 allow word accesses despite byte-wide strap
// - bit 2 on write commands: every floppy sector gets deleted marker
// - marker precedes data on write; read interprets but drops it
// - bit 7 clear: skip deleted if bit 2 is 0, else skip normal
// - bit 7 set: skip deleted, or with bit 2 stop with code 423
// - skipped sectors read at disk but not stored or counted
// - programmed reset clears pending, deselects, aborts write, unloads
// - first start after clear chains tables from strap address only
// - after chaining, busy byte cleared without posting status
// - overlapped command may post seek-complete or ready status
// - bits 6 and 5 act only with bit 7 and extended strap
// - modifier bit 1 set: no automatic error retries
// - status written only when semaphore zero, else queued and polled
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define DTC_A_CMD     8'h00
`define DTC_A_PARAM   8'h04
`define DTC_A_STAT    8'h08
`define DTC_A_SEM     8'h0C
`define DTC_A_EVT     8'h10
`define DTC_A_CNT     8'h14
`define DTC_A_CHAN    8'h18
// ----------------------------------------
// command and field positions
// ----------------------------------------
`define DTC_CMD_RESET 0
`define DTC_CMD_CLEAR 1
`define DTC_CMD_START 2
`define DTC_PAR_FLOP  16
`define DTC_M_NOIRQ   0
`define DTC_M_NORTRY  1
`define DTC_M_DELAM   2
`define DTC_M_WORD    5
`define DTC_M_DIRECT  6
`define DTC_M_EXT     7
// ----------------------------------------
// opcodes, status codes, table layout
// ----------------------------------------
`define DTC_OP_RD     8'h04
`define DTC_OP_WR     8'h06
`define DTC_OP_RVFY   8'h05
`define DTC_OP_WRBUF  8'h0A
`define DTC_ST_DONE   8'h01
`define DTC_ST_ERR    8'h81
`define DTC_ST_SEEK   8'h02
`define DTC_ST_READY  8'h03
`define DTC_EVT_DEL   16'h0423
`define DTC_BUSY_OFS  24'h00_0001
`define DTC_WAKE_LOW  20'h0_0000
`endif

// *** src/dtc_top.v ***
/*
 command handling and transfer control of the disk controller.
 assumes an apb master, a table memory port with ack, and a disk
 datapath on pclk giving byte, sector and end pulses.
*/
`timescale 1ns/1ps
`include "dtc_defs.vh"
module dtc_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        floppy_transfer_strap_a,
  input  wire        floppy_transfer_strap_b,
  input  wire        word_transfer_strap,
  input  wire [3:0]  wake_strap,
  output wire        mem_req,
  output wire        mem_we,
  output wire [23:0] mem_addr,
  output wire [7:0]  mem_wdata,
  input  wire [23:0] mem_rdata,
  input  wire        mem_ack,
  input  wire        dsk_byte,
  input  wire        dsk_sector_start,
  input  wire        dsk_marker_del,
  input  wire        dsk_sector_end,
  input  wire        dsk_late,
  input  wire        dsk_cmd_end,
  input  wire        seek_done,
  input  wire        drive_ready,
  output wire        dma_req,
  output wire        mem_lock,
  output wire        xfer_word,
  output wire        xfer_direct,
  output wire        marker_del_wr,
  output wire        skip_sector,
  output wire        retry_inhibit,
  output reg         cmd_irq,
  output wire        drv_deselect,
  output wire        write_abort,
  output wire        head_unload
);
  localparam [2:0] S_RST  = 3'd0;
  localparam [2:0] S_IDLE = 3'd1;
  localparam [2:0] S_WAKE = 3'd2;
  localparam [2:0] S_CLRB = 3'd3;
  localparam [2:0] S_RUN  = 3'd4;
  localparam [2:0] S_DONE = 3'd5;

  // ----------------------------------------
  // strap synchronisers
  // ----------------------------------------
  wire [6:0] strap_in;
  reg  [6:0] strap_m_q;
  reg  [6:0] strap_s_q;
  assign strap_in = {wake_strap, word_transfer_strap,
                     floppy_transfer_strap_b, floppy_transfer_strap_a};
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          strap_m_q[gi] <= 1'b0;
          strap_s_q[gi] <= 1'b0;
        end else begin
          strap_m_q[gi] <= strap_in[gi];
          strap_s_q[gi] <= strap_m_q[gi];
        end
      end
    end
  endgenerate
  wire sa_s   = strap_s_q[0];
  wire sb_s   = strap_s_q[1];
  wire word_s = strap_s_q[2];

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [2:0]  st_q;
  reg        core_rst_q;
  reg        first_q;
  reg        busy_q;
  reg [16:0] param_q;
  reg [7:0]  mod_q;
  reg [7:0]  op_q;
  reg        flop_q;
  reg [23:0] chan_q;
  reg        sem_q;
  reg [7:0]  op_status_q;
  reg [2:0]  pend_q;
  reg        err_q;
  reg [15:0] evt_q;
  reg [15:0] cnt_q;
  reg [15:0] sec_cnt_q;
  reg        recover_q;
  reg        skip_q;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup  = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire mapped = (paddr == `DTC_A_CMD) | (paddr == `DTC_A_PARAM) |
                (paddr == `DTC_A_STAT) | (paddr == `DTC_A_SEM) |
                (paddr == `DTC_A_EVT) | (paddr == `DTC_A_CNT) |
                (paddr == `DTC_A_CHAN);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  wire cmd_wr  = wr_acc & (paddr == `DTC_A_CMD);
  wire do_rst  = cmd_wr & pwdata[`DTC_CMD_RESET];
  wire do_clr  = cmd_wr & pwdata[`DTC_CMD_CLEAR] & ~do_rst;
  wire do_go   = cmd_wr & pwdata[`DTC_CMD_START] & ~core_rst_q;
  wire sem_clr = wr_acc & (paddr == `DTC_A_SEM) & ~pwdata[8];

  // ----------------------------------------
  // modifier decode
  // ----------------------------------------
  wire run    = (st_q == S_RUN);
  wire ext    = mod_q[`DTC_M_EXT] & sa_s;
  wire op_rw  = (op_q == `DTC_OP_RD) | (op_q == `DTC_OP_WR);
  wire op_rd  = (op_q == `DTC_OP_RD) | (op_q == `DTC_OP_RVFY);
  wire op_wr  = (op_q == `DTC_OP_WR) | (op_q == `DTC_OP_WRBUF);
  wire dir_fl = sa_s & sb_s;
  wire dir_hd = ext & mod_q[`DTC_M_DIRECT];
  wire dir_en = op_rw & (flop_q ? dir_fl : dir_hd);
  wire dir_act = run & dir_en & ~recover_q;
  assign xfer_direct = dir_act;
  assign mem_lock    = dir_act & ~flop_q;
  assign xfer_word   = word_s | (ext & mod_q[`DTC_M_WORD]);
  assign marker_del_wr = run & flop_q & op_wr &
                         mod_q[`DTC_M_DELAM];
  assign retry_inhibit = run & mod_q[`DTC_M_NORTRY];
  assign skip_sector   = run & skip_q;
  assign dma_req = dir_act & dsk_byte & ~skip_q;
  assign drv_deselect = core_rst_q;
  assign write_abort  = core_rst_q;
  assign head_unload  = core_rst_q;

  // ----------------------------------------
  // floppy marker filter
  // ----------------------------------------
  wire fl_rd  = run & flop_q & op_rd & dsk_sector_start;
  wire m7     = mod_q[`DTC_M_EXT];
  wire m2     = mod_q[`DTC_M_DELAM];
  wire skip_d = m7 ? (dsk_marker_del & ~m2)
                   : (m2 ? ~dsk_marker_del : dsk_marker_del);
  wire del_stop = fl_rd & m7 & m2 & dsk_marker_del;
  wire cmd_end  = run & (dsk_cmd_end | del_stop);

  // ----------------------------------------
  // status queue and semaphore
  // ----------------------------------------
  wire [2:0] ev_new = {cmd_end, run & seek_done,
                       run & drive_ready};
  wire       can_post = ~sem_q & (pend_q != 3'b000);
  reg  [2:0] post_sel;
  reg  [7:0] post_code;
  always @* begin
    post_sel  = 3'b000;
    post_code = `DTC_ST_DONE;
    if (pend_q[2]) begin
      post_sel  = 3'b100;
      post_code = err_q ? `DTC_ST_ERR : `DTC_ST_DONE;
    end else if (pend_q[1]) begin
      post_sel  = 3'b010;
      post_code = `DTC_ST_SEEK;
    end else if (pend_q[0]) begin
      post_sel  = 3'b001;
      post_code = `DTC_ST_READY;
    end
  end
  wire [2:0] posted = can_post ? post_sel : 3'b000;

  // ----------------------------------------
  // table memory port
  // ----------------------------------------
  assign mem_req   = (st_q == S_WAKE) | (st_q == S_CLRB);
  assign mem_we    = (st_q == S_CLRB);
  assign mem_addr  = (st_q == S_WAKE) ? {strap_s_q[6:3], `DTC_WAKE_LOW}
                     : chan_q + `DTC_BUSY_OFS;
  assign mem_wdata = 8'h00;

  // ----------------------------------------
  // control sequencer
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q        <= S_RST;
      core_rst_q  <= 1'b1;
      first_q     <= 1'b0;
      busy_q      <= 1'b0;
      param_q     <= 17'h0_0000;
      mod_q       <= 8'h00;
      op_q        <= 8'h00;
      flop_q      <= 1'b0;
      chan_q      <= 24'h00_0000;
      sem_q       <= 1'b0;
      op_status_q <= 8'h00;
      pend_q      <= 3'b000;
      err_q       <= 1'b0;
      evt_q       <= 16'h0000;
      cnt_q       <= 16'h0000;
      sec_cnt_q   <= 16'h0000;
      recover_q   <= 1'b0;
      skip_q      <= 1'b0;
      cmd_irq     <= 1'b0;
    end else begin
      cmd_irq <= 1'b0;
      if (wr_acc & (paddr == `DTC_A_PARAM))
        param_q <= pwdata[16:0];
      if (can_post) begin
        sem_q       <= 1'b1;
        op_status_q <= post_code;
        if (post_sel[2])
          cmd_irq <= ~mod_q[`DTC_M_NOIRQ];
      end else if (sem_clr) begin
        sem_q <= 1'b0;
      end
      pend_q <= (pend_q & ~posted) | ev_new;
      if (do_rst) begin
        core_rst_q <= 1'b1;
        pend_q     <= 3'b000;
        cmd_irq    <= 1'b0;
        st_q       <= S_RST;
        skip_q     <= 1'b0;
        recover_q  <= 1'b0;
      end else begin
        case (st_q)
          S_RST: begin
            if (do_clr) begin
              core_rst_q <= 1'b0;
              first_q    <= 1'b1;
              st_q       <= S_IDLE;
            end
          end
          S_IDLE: begin
            if (do_go & first_q) begin
              busy_q <= 1'b1;
              st_q   <= S_WAKE;
            end else if (do_go & ~busy_q) begin
              busy_q    <= 1'b1;
              mod_q     <= param_q[7:0];
              op_q      <= param_q[15:8];
              flop_q    <= param_q[`DTC_PAR_FLOP];
              err_q     <= 1'b0;
              evt_q     <= 16'h0000;
              cnt_q     <= 16'h0000;
              sec_cnt_q <= 16'h0000;
              recover_q <= 1'b0;
              skip_q    <= 1'b0;
              st_q      <= S_RUN;
            end
          end
          S_WAKE: begin
            if (mem_ack) begin
              chan_q <= mem_rdata;
              st_q  <= S_CLRB;
            end
          end
          S_CLRB: begin
            if (mem_ack) begin
              busy_q  <= 1'b0;
              first_q <= 1'b0;
              st_q    <= S_IDLE;
            end
          end
          S_RUN: begin
            if (dsk_sector_start) begin
              sec_cnt_q <= 16'h0000;
              skip_q    <= fl_rd & skip_d;
            end
            if (dsk_late & dir_act) begin
              cnt_q     <= cnt_q - sec_cnt_q;
              sec_cnt_q <= 16'h0000;
              recover_q <= 1'b1;
            end else if (dsk_byte & ~skip_q) begin
              cnt_q     <= cnt_q + 16'h0001;
              sec_cnt_q <= sec_cnt_q + 16'h0001;
            end
            if (dsk_sector_end & ~dsk_late) begin
              recover_q <= 1'b0;
              skip_q    <= 1'b0;
            end
            if (del_stop) begin
              err_q <= 1'b1;
              evt_q <= `DTC_EVT_DEL;
            end
            if (cmd_end)
              st_q <= S_DONE;
          end
          S_DONE: begin
            if (~pend_q[2])
              st_q <= S_CLRB;
          end
          default: st_q <= S_RST;
        endcase
      end
    end
  end

  // ----------------------------------------
  // apb read data
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      if (paddr == `DTC_A_PARAM)
        prdata <= {15'h0000, param_q};
      else if (paddr == `DTC_A_STAT)
        prdata <= {22'h00_0000, err_q, first_q, skip_q, recover_q,
                   dir_act, core_rst_q, st_q, busy_q};
      else if (paddr == `DTC_A_SEM)
        prdata <= {23'h00_0000, sem_q, op_status_q};
      else if (paddr == `DTC_A_EVT)
        prdata <= {16'h0000, evt_q};
      else if (paddr == `DTC_A_CNT)
        prdata <= {16'h0000, cnt_q};
      else if (paddr == `DTC_A_CHAN)
        prdata <= {8'h00, chan_q};
      else
        prdata <= 32'h0000_0000;
    end
  end
endmodule

// *** test/dtc_asserts.sv ***
/*
 port assertions for dtc_top.
 assumes a bind to every dtc_top instance.
*/
`timescale 1ns/1ps
module dtc_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        word_transfer_strap,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        dsk_byte,
  input wire logic        dsk_late,
  input wire logic        dma_req,
  input wire logic        mem_lock,
  input wire logic        xfer_word,
  input wire logic        xfer_direct,
  input wire logic        marker_del_wr,
  input wire logic        skip_sector,
  input wire logic        retry_inhibit,
  input wire logic        cmd_irq,
  input wire logic        drv_deselect
);
  logic [16:0] par_q;
  logic [8:0]  cap_q;
  wire         wr = psel && penable && pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_q <= 17'h0_0000;
      cap_q <= 9'h000;
    end else if (wr && paddr == 8'h04) begin
      par_q <= pwdata[16:0];
    end else if (wr && paddr == 8'h00 && pwdata[2]) begin
      cap_q <= {par_q[16], par_q[7:0]};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_no_irq: assert property (cap_q[0] |-> !cmd_irq)
    else $error("irq while suppressed");
  chk_lock_cause: assert property (mem_lock |-> xfer_direct
    && cap_q[7:6] == 2'h3 && !cap_q[8]) else $error("bad bus lock");
  chk_dma_byte: assert property (dma_req |-> dsk_byte
    && xfer_direct && !skip_sector) else $error("bad memory access");
  chk_late_drop: assert property (dsk_late && xfer_direct
    |=> !xfer_direct [*2]) else $error("direct kept after late");
  chk_word_cause: assert property (xfer_word |-> word_transfer_strap
    || cap_q[7] && cap_q[5]) else $error("bad word width");
  chk_del_mark: assert property (marker_del_wr |-> cap_q[2] && cap_q[8])
    else $error("bad deleted marker");
  chk_retry_off: assert property (retry_inhibit |-> cap_q[1])
    else $error("bad retry inhibit");
  chk_reset_cmd: assert property (wr && paddr == 8'h00 && pwdata[0]
    |=> drv_deselect) else $error("drive kept selected");
  chk_wake_addr: assert property (mem_req && !mem_we
    |-> mem_addr[19:0] == 20'h0_0000) else $error("bad wake address");
  chk_req_hold: assert property (mem_req && !mem_ack
    |=> mem_req && $stable(mem_addr)) else $error("table request lost");
endmodule

bind dtc_top dtc_asserts chk_i (.*);

// *** test/dtc_host_mem.sv ***
/*
 host table memory model for dtc_top.
 assumes one table request at a time, held until acknowledged.
*/
`timescale 1ns/1ps
module dtc_host_mem #(parameter logic [23:0] PTR = 24'h00_1000) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [1:0]  lag,
  output logic             mem_ack,
  output logic [23:0]      mem_rdata,
  output logic [23:0]      wr_addr_q
);
  logic [1:0] wait_q;
  assign mem_rdata = mem_ack ? PTR : ~PTR;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q    <= 2'h0;
      mem_ack   <= 1'h0;
      wr_addr_q <= 24'h00_0000;
    end else begin
      mem_ack <= 1'h0;
      if (mem_req && !mem_ack && wait_q != lag) begin
        wait_q <= wait_q + 2'h1;
      end else if (mem_req && !mem_ack) begin
        wait_q  <= 2'h0;
        mem_ack <= 1'h1;
        if (mem_we)
          wr_addr_q <= mem_addr;
      end
    end
  end
endmodule

// *** test/dtc_tb_top.sv ***
/*
 dtc_top bench: apb tasks and disk pulse sequences.
 assumes dtc_host_mem on the table port.
*/
`timescale 1ns/1ps
`include "dtc_defs.vh"
module dtc_tb_top;
  localparam logic [23:0] PTR = 24'h01_2340;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, dsk_marker_del = 1'h0, errv, dma_seen;
  logic floppy_transfer_strap_a = 1'h1, floppy_transfer_strap_b = 1'h1;
  logic word_transfer_strap = 1'h0, pready, pslverr, mem_req, mem_we;
  logic mem_ack, dma_req, mem_lock, xfer_word, xfer_direct, cmd_irq;
  logic marker_del_wr, skip_sector, retry_inhibit, drv_deselect;
  logic write_abort, head_unload;
  logic [3:0] wake_strap = 4'h3;
  logic [6:0] dp = 7'h00;
  logic [1:0] lag = 2'h0;
  logic [7:0] paddr = 8'h00, mem_wdata, mods [3] = '{8'h00, 8'h04, 8'h80};
  logic [23:0] mem_addr, mem_rdata, wr_addr_q;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
  int mismatches = 0, tests_run = 0, irq_n = 0, i0, n;
  wire dsk_byte, dsk_sector_start, dsk_sector_end, dsk_late, dsk_cmd_end;
  wire seek_done, drive_ready;
  assign {drive_ready, seek_done, dsk_cmd_end, dsk_late, dsk_sector_end,
          dsk_sector_start, dsk_byte} = dp;
  dtc_top dut (.*);
  dtc_host_mem #(.PTR(PTR)) mem (.*);
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) if (cmd_irq === 1'h1) irq_n <= irq_n + 1;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic pulse(input logic [6:0] v, input logic del = 1'h0);
    dp <= v;
    dsk_marker_del <= del;
    @(negedge pclk);
    dma_seen = dma_req;
    @(posedge pclk);
    dp <= 7'h00;
    @(posedge pclk);
  endtask
  task automatic go(input logic [7:0] m, op, input logic f);
    i0 = irq_n;
    apb(1, `DTC_A_PARAM, {15'h0000, f, op, m});
    apb(1, `DTC_A_CMD, 4);
  endtask
  task automatic fin(input logic [7:0] st, input int irq, input logic e);
    if (e) pulse(7'h10);
    n = 0;
    do begin
      apb(0, `DTC_A_STAT, 0);
      n++;
    end while (rdv[0] !== 1'h0 && n < 40);
    chk(rdv[0], 1'h0);
    chk(irq_n - i0, irq);
    apb(0, `DTC_A_SEM, 0);
    chk(rdv, {23'h00_0000, st != 8'h00, st});
    apb(1, `DTC_A_SEM, 0);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    results();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk({drv_deselect, write_abort, head_unload}, 3'h7);
    apb(1, `DTC_A_SEM, 0);
    apb(1, `DTC_A_CMD, 2);
    i0 = irq_n;
    apb(1, `DTC_A_CMD, 4);
    fin(8'h00, 0, 1'h0);
    apb(0, `DTC_A_CHAN, 0);
    chk(rdv, {8'h00, PTR});
    chk(wr_addr_q, PTR + `DTC_BUSY_OFS);
    chk(mem_wdata, 8'h00);
    apb(0, 8'h1C, 0);
    chk(errv, 1'h1);
    chk(rdv, 32'h0000_0000);
    lag <= 2'h2;
    go(8'hC0, `DTC_OP_RD, 1'h0);
    chk({xfer_direct, mem_lock}, 2'h3);
    pulse(7'h02);
    repeat (3) begin
      pulse(7'h01);
      chk(dma_seen, 1'h1);
    end
    apb(1, `DTC_A_PARAM, 0);
    chk(xfer_direct, 1'h1);
    pulse(7'h08);
    chk({xfer_direct, mem_lock}, 2'h0);
    apb(0, `DTC_A_CNT, 0);
    chk(rdv, 0);
    pulse(7'h01);
    chk(dma_seen, 1'h0);
    pulse(7'h04);
    fin(`DTC_ST_DONE, 1, 1'h1);
    for (int i = 0; i < 3; i++) begin
      go(mods[i], `DTC_OP_RD, 1'h1);
      chk({xfer_direct, mem_lock}, 2'h2);
      for (int j = 0; j < 2; j++) begin
        pulse(7'h02, j[0]);
        chk(skip_sector, j[0] ^ mods[i][2]);
        repeat (2) pulse(7'h01);
        pulse(7'h04);
      end
      apb(0, `DTC_A_CNT, 0);
      chk(rdv, 2);
      fin(`DTC_ST_DONE, 1, 1'h1);
    end
    go(8'h84, `DTC_OP_RD, 1'h1);
    pulse(7'h02, 1'h1);
    pulse(7'h04);
    fin(`DTC_ST_ERR, 1, 1'h1);
    apb(0, `DTC_A_EVT, 0);
    chk(rdv, {16'h0000, `DTC_EVT_DEL});
    go(8'h07, `DTC_OP_WR, 1'h1);
    chk({marker_del_wr, retry_inhibit}, 2'h3);
    fin(`DTC_ST_DONE, 0, 1'h1);
    go(8'hA0, `DTC_OP_WRBUF, 1'h1);
    chk({xfer_word, marker_del_wr}, 2'h2);
    pulse(7'h40);
    apb(0, `DTC_A_SEM, 0);
    chk(rdv, 32'h0000_0103);
    apb(1, `DTC_A_SEM, 0);
    fin(`DTC_ST_DONE, 1, 1'h1);
    go(8'h20, `DTC_OP_RVFY, 1'h0);
    chk(xfer_word, 1'h0);
    pulse(7'h20);
    pulse(7'h10);
    apb(0, `DTC_A_STAT, 0);
    chk(rdv[0], 1'h1);
    apb(0, `DTC_A_SEM, 0);
    chk(rdv, 32'h0000_0102);
    apb(1, `DTC_A_SEM, 0);
    fin(`DTC_ST_DONE, 1, 1'h0);
    apb(1, `DTC_A_CMD, 1);
    chk({drv_deselect, write_abort, head_unload}, 3'h7);
    results();
  end
endmodule
